// File: common/fepc_defines.svh
// register map, field positions, reset values and keys of the flash control
`ifndef FEPC_DEFINES_SVH
`define FEPC_DEFINES_SVH
`define FEPC_ADDR_ERASE_CMD 8'h94
`define FEPC_ADDR_PROG_CTRL 8'hb2
`define FEPC_ADDR_PAGE_SEL 8'hb7
`define FEPC_BIT_PWE 0
`define FEPC_BIT_BULK_EN 1
`define FEPC_PAGE_MSB 7
`define FEPC_PAGE_LSB 1
`define FEPC_KEY_PAGE 8'h55
`define FEPC_KEY_BULK 8'haa
`define FEPC_RST_ERASE_CMD 8'h00
`define FEPC_RST_PAGE 7'h00
`endif

// File: common/fepc_pkg.sv
// types shared by the flash erase and program control
package fepc_pkg;
  typedef enum logic [1:0] {ERS_NONE, ERS_PAGE, ERS_BULK} fepc_erase_e;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fepc_sfr_wr_s;

  typedef struct packed {
    logic valid;
    fepc_erase_e kind;
    logic [6:0] page;
  } fepc_erase_req_s;
endpackage : fepc_pkg

// File: logic/fepc_flash_ctrl.sv
// flash erase and byte program control behind the special registers
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module fepc_flash_ctrl #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire fepc_pkg::fepc_sfr_wr_s sfr_wr,
  input wire logic [7:0] sfr_raddr,
  input wire logic int_global_en,
  input wire logic debug_port_en,
  input wire logic movx_wr,
  input wire logic [ADDR_W-1:0] movx_addr,
  input wire logic [7:0] movx_data,
  output logic [7:0] sfr_rdata,
  output fepc_pkg::fepc_erase_req_s erase_req,
  output logic flash_wr,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_data,
  output logic xdata_wr,
  output logic [ADDR_W-1:0] xdata_addr,
  output logic [7:0] xdata_data
);
`include "fepc_defines.svh"

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] erase_cmd;
    logic [6:0] page;
    logic page_armed;
    logic bulk_armed;
    logic pwe;
    fepc_pkg::fepc_erase_req_s req;
    logic fwr;
    logic xwr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [7:0] rdata;
  } fepc_state_s;

  fepc_state_s s_q;
  fepc_state_s s_d;
  fepc_pkg::fepc_erase_e kind;
  logic to_flash;
  logic to_xdata;
  logic wr_cmd;
  logic wr_ctrl;
  logic wr_page;

  assign wr_cmd = sfr_wr.wr && sfr_wr.addr == `FEPC_ADDR_ERASE_CMD;
  assign wr_ctrl = sfr_wr.wr && sfr_wr.addr == `FEPC_ADDR_PROG_CTRL;
  assign wr_page = sfr_wr.wr && sfr_wr.addr == `FEPC_ADDR_PAGE_SEL;

  fepc_key_decode u_key (
    .key(sfr_wr.wdata),
    .page_armed(s_q.page_armed),
    .bulk_armed(s_q.bulk_armed),
    .debug_port_en(debug_port_en),
    .kind(kind)
  );

  fepc_movx_route u_route (
    .movx_wr(movx_wr),
    .pwe(s_q.pwe),
    .to_flash(to_flash),
    .to_xdata(to_xdata)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.req = '{valid: 1'b0, kind: fepc_pkg::ERS_NONE, page: s_q.page};
    s_d.fwr = 1'b0;
    s_d.xwr = 1'b0;
    if (wr_page)
    begin
      s_d.page = sfr_wr.wdata[`FEPC_PAGE_MSB:`FEPC_PAGE_LSB];
      s_d.page_armed = 1'b1;
    end
    if (wr_ctrl)
    begin
      s_d.bulk_armed = sfr_wr.wdata[`FEPC_BIT_BULK_EN];
      if (!int_global_en)
      begin
        s_d.pwe = sfr_wr.wdata[`FEPC_BIT_PWE];
      end
    end
    if (wr_cmd)
    begin
      s_d.erase_cmd = sfr_wr.wdata;
      // a used arm is dropped so a stale setting cannot repeat an erase
      case (kind)
        fepc_pkg::ERS_PAGE:
        begin
          s_d.req = '{valid: 1'b1, kind: kind, page: s_q.page};
          s_d.page_armed = 1'b0;
        end
        fepc_pkg::ERS_BULK:
        begin
          s_d.req = '{valid: 1'b1, kind: kind, page: s_q.page};
          s_d.bulk_armed = 1'b0;
        end
        default:
        begin
          s_d.req.valid = 1'b0;
        end
      endcase
    end
    if (movx_wr)
    begin
      s_d.addr = movx_addr;
      s_d.data = movx_data;
      s_d.fwr = to_flash;
      s_d.xwr = to_xdata;
    end
    if (to_flash)
    begin
      // the byte store wins over a same-cycle register write
      s_d.pwe = 1'b0;
    end
    // only program write enable reads back; the rest are write-only
    s_d.rdata = 8'h00;
    if (sfr_raddr == `FEPC_ADDR_PROG_CTRL)
    begin
      s_d.rdata[`FEPC_BIT_PWE] = s_d.pwe;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.erase_cmd <= `FEPC_RST_ERASE_CMD;
      s_q.page <= `FEPC_RST_PAGE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign erase_req = s_q.req;
  assign flash_wr = s_q.fwr;
  assign xdata_wr = s_q.xwr;
  assign flash_addr = s_q.addr;
  assign xdata_addr = s_q.addr;
  assign flash_data = s_q.data;
  assign xdata_data = s_q.data;
  assign sfr_rdata = s_q.rdata;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_page_start: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd && sfr_wr.wdata == `FEPC_KEY_PAGE && s_q.page_armed)
    |=> (erase_req.valid && erase_req.kind == fepc_pkg::ERS_PAGE
         && erase_req.page == $past(s_q.page)))
    else $error("page erase not started");
  a_bulk_start: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd && sfr_wr.wdata == `FEPC_KEY_BULK && s_q.bulk_armed
     && debug_port_en)
    |=> (erase_req.valid && erase_req.kind == fepc_pkg::ERS_BULK))
    else $error("bulk erase not started");
  a_bad_key: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd && sfr_wr.wdata != `FEPC_KEY_PAGE
     && sfr_wr.wdata != `FEPC_KEY_BULK) |=> !erase_req.valid)
    else $error("erase from a non-key write");
  a_no_cmd: assert property (@(posedge clk) disable iff (!rstn)
    !wr_cmd |=> !erase_req.valid)
    else $error("erase without a command write");
  a_bulk_gate: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd && !(s_q.bulk_armed && debug_port_en))
    |=> erase_req.kind != fepc_pkg::ERS_BULK)
    else $error("bulk erase without preconditions");
  a_page_rearm: assert property (@(posedge clk) disable iff (!rstn)
    (erase_req.valid && erase_req.kind == fepc_pkg::ERS_PAGE)
    |-> !s_q.page_armed || $past(wr_page))
    else $error("page select still armed after erase");
  a_xdata_path: assert property (@(posedge clk) disable iff (!rstn)
    (movx_wr && !s_q.pwe) |=> (xdata_wr && !flash_wr
                               && xdata_addr == $past(movx_addr)))
    else $error("store not routed to external data");
  a_flash_byte: assert property (@(posedge clk) disable iff (!rstn)
    (movx_wr && s_q.pwe) |=> (flash_wr && !xdata_wr
                              && flash_data == $past(movx_data)))
    else $error("store not routed to flash");
  a_pwe_clear: assert property (@(posedge clk) disable iff (!rstn)
    (movx_wr && s_q.pwe) |=> !s_q.pwe)
    else $error("program enable not cleared");
  a_pwe_lock: assert property (@(posedge clk) disable iff (!rstn)
    (wr_ctrl && int_global_en && !to_flash) |=> s_q.pwe == $past(s_q.pwe))
    else $error("program enable changed with interrupts on");
  a_bulk_field: assert property (@(posedge clk) disable iff (!rstn)
    (wr_ctrl && !wr_cmd) |=> s_q.bulk_armed == $past(sfr_wr.wdata[1]))
    else $error("bulk enable not stored");
  a_page_field: assert property (@(posedge clk) disable iff (!rstn)
    wr_page |=> s_q.page == $past(sfr_wr.wdata[7:1]))
    else $error("page select not stored");

  // ----------------------------------------------------------------------
  // checks on held state and outputs
  // ----------------------------------------------------------------------
  // held state moves only on its own write, on the erase that uses an arm, or, for pwe, on a flash byte; a stray change would
  // erase or program the wrong place long after the software wrote it
  a_route_excl: assert property (@(posedge clk) disable iff (!rstn)
    !(flash_wr && xdata_wr))
    else $error("store routed to both spaces");
  a_req_pulse: assert property (@(posedge clk) disable iff (!rstn)
    (erase_req.valid && !wr_cmd) |=> !erase_req.valid)
    else $error("erase request held too long");
  a_req_kind: assert property (@(posedge clk) disable iff (!rstn)
    erase_req.valid |-> erase_req.kind != fepc_pkg::ERS_NONE)
    else $error("erase request without a kind");
  a_idle_kind: assert property (@(posedge clk) disable iff (!rstn)
    !erase_req.valid |-> erase_req.kind == fepc_pkg::ERS_NONE)
    else $error("erase kind shown without request");
  a_cmd_store: assert property (@(posedge clk) disable iff (!rstn)
    wr_cmd |=> s_q.erase_cmd == $past(sfr_wr.wdata))
    else $error("erase command not stored");
  a_cmd_hold: assert property (@(posedge clk) disable iff (!rstn)
    !wr_cmd |=> $stable(s_q.erase_cmd))
    else $error("erase command changed without write");
  a_page_hold: assert property (@(posedge clk) disable iff (!rstn)
    !wr_page |=> $stable(s_q.page))
    else $error("page select changed without write");
  a_page_arm: assert property (@(posedge clk) disable iff (!rstn)
    wr_page |=> s_q.page_armed)
    else $error("page select write did not arm");
  a_page_gate: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd && !s_q.page_armed)
    |=> erase_req.kind != fepc_pkg::ERS_PAGE)
    else $error("page erase without page select");
  a_bulk_hold: assert property (@(posedge clk) disable iff (!rstn)
    (!wr_ctrl && !wr_cmd) |=> $stable(s_q.bulk_armed))
    else $error("bulk enable changed without write");
  a_bulk_used: assert property (@(posedge clk) disable iff (!rstn)
    (erase_req.valid && erase_req.kind == fepc_pkg::ERS_BULK)
    |-> !s_q.bulk_armed)
    else $error("bulk enable still armed after erase");
  a_bulk_debug: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd && !debug_port_en)
    |=> erase_req.kind != fepc_pkg::ERS_BULK)
    else $error("bulk erase with debug port off");
  a_pwe_read: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_raddr == `FEPC_ADDR_PROG_CTRL) |=> sfr_rdata[0] == s_q.pwe)
    else $error("program enable read back wrong");
  a_rdata_high: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> sfr_rdata[7:1] == 7'h00)
    else $error("write-only bits read back");
  a_rdata_other: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_raddr != `FEPC_ADDR_PROG_CTRL) |=> sfr_rdata == 8'h00)
    else $error("write-only register read back");
  a_pwe_hold: assert property (@(posedge clk) disable iff (!rstn)
    (!wr_ctrl && !to_flash) |=> $stable(s_q.pwe))
    else $error("program enable changed without cause");
  a_xdata_data: assert property (@(posedge clk) disable iff (!rstn)
    (movx_wr && !s_q.pwe) |=> xdata_data == $past(movx_data))
    else $error("external data byte wrong");
  a_flash_addr: assert property (@(posedge clk) disable iff (!rstn)
    (movx_wr && s_q.pwe) |=> flash_addr == $past(movx_addr))
    else $error("flash address wrong");
  a_no_store: assert property (@(posedge clk) disable iff (!rstn)
    !movx_wr |=> (!flash_wr && !xdata_wr))
    else $error("store strobe without request");
  a_store_hold: assert property (@(posedge clk) disable iff (!rstn)
    !movx_wr |=> ($stable(flash_addr) && $stable(flash_data)))
    else $error("store address or data moved while idle");
  a_pwe_one: assert property (@(posedge clk) disable iff (!rstn)
    flash_wr |-> !s_q.pwe)
    else $error("program enable survived a flash byte");
  a_pwe_set: assert property (@(posedge clk) disable iff (!rstn)
    (wr_ctrl && !int_global_en && !to_flash)
    |=> s_q.pwe == $past(sfr_wr.wdata[0]))
    else $error("program enable not stored");
endmodule : fepc_flash_ctrl
`default_nettype wire

// File: logic/fepc_key_decode.sv
// decodes a write of the erase command register into an erase request kind
`timescale 1ns/1ps
`default_nettype none
module fepc_key_decode (
  input wire logic [7:0] key,
  input wire logic page_armed,
  input wire logic bulk_armed,
  input wire logic debug_port_en,
  output fepc_pkg::fepc_erase_e kind
);
`include "fepc_defines.svh"
  always_comb
  begin
    kind = fepc_pkg::ERS_NONE;
    // preconditions checked at the moment of the key write
    if (key == `FEPC_KEY_PAGE && page_armed)
    begin
      kind = fepc_pkg::ERS_PAGE;
    end
    else if (key == `FEPC_KEY_BULK && bulk_armed && debug_port_en)
    begin
      kind = fepc_pkg::ERS_BULK;
    end
  end
endmodule : fepc_key_decode
`default_nettype wire

// File: logic/fepc_movx_route.sv
// steers a data-pointer store either to external data space or to flash
`timescale 1ns/1ps
`default_nettype none
module fepc_movx_route (
  input wire logic movx_wr,
  input wire logic pwe,
  output logic to_flash,
  output logic to_xdata
);
  // one store goes to exactly one space
  assign to_flash = movx_wr & pwe;
  assign to_xdata = movx_wr & ~pwe;
endmodule : fepc_movx_route
`default_nettype wire

// File: tb/fepc_cpu_model.sv
// processor-side model: special register writes, reads and stores
`timescale 1ns/1ps
`default_nettype none
module fepc_cpu_model (
  input wire logic clk,
  input wire logic [7:0] sfr_rdata,
  output fepc_pkg::fepc_sfr_wr_s sfr_wr,
  output logic [7:0] sfr_raddr,
  output logic movx_wr,
  output logic [15:0] movx_addr,
  output logic [7:0] movx_data
);
  // --------------------------------
  // bus cycles
  // --------------------------------
  initial
  begin
    sfr_wr = '0;
    sfr_raddr = 8'h00;
    movx_wr = 1'b0;
    movx_addr = 16'h0000;
    movx_data = 8'h00;
  end

  // released lines show the inverse so stale values cannot pass
  // software rewrites arm bits before each erase
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    sfr_wr <= '{wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic st(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    movx_wr <= 1'b1;
    movx_addr <= a;
    movx_data <= d;
    @(posedge clk);
    movx_wr <= 1'b0;
    movx_addr <= ~a;
    movx_data <= ~d;
  endtask : st

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_raddr <= a;
    @(posedge clk);
    #1 d = sfr_rdata;
  endtask : rd
endmodule : fepc_cpu_model
`default_nettype wire

// File: tb/flash_erase_program_control_bench.sv
// self-checking bench for the flash erase and program control
`timescale 1ns/1ps
`default_nettype none
module flash_erase_program_control_bench;
  logic clk;
  logic rstn;
  logic int_global_en;
  logic debug_port_en;
  logic movx_wr, flash_wr, xdata_wr;
  logic [7:0] sfr_raddr, sfr_rdata, movx_data, flash_data, xdata_data, rd;
  logic [15:0] movx_addr, flash_addr, xdata_addr;
  fepc_pkg::fepc_sfr_wr_s sfr_wr;
  fepc_pkg::fepc_erase_req_s erase_req;
  int failures;
  int cmp_count;
  logic [7:0] bad_keys [4] = '{8'h54, 8'h56, 8'hab, 8'hff};

  fepc_cpu_model i_fepc_cpu_model (.clk(clk), .sfr_rdata(sfr_rdata),
    .sfr_wr(sfr_wr), .sfr_raddr(sfr_raddr), .movx_wr(movx_wr),
    .movx_addr(movx_addr), .movx_data(movx_data));
  fepc_flash_ctrl #(.ADDR_W(16)) i_fepc_flash_ctrl (.clk(clk), .rstn(rstn),
    .sfr_wr(sfr_wr), .sfr_raddr(sfr_raddr), .int_global_en(int_global_en),
    .debug_port_en(debug_port_en), .movx_wr(movx_wr),
    .movx_addr(movx_addr), .movx_data(movx_data), .sfr_rdata(sfr_rdata),
    .erase_req(erase_req), .flash_wr(flash_wr), .flash_addr(flash_addr),
    .flash_data(flash_data), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
    .xdata_data(xdata_data));

  // --------------------------------
  // compare and report
  // --------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // erase pulse is looked at in the one cycle it stands
  task automatic key(input logic [7:0] k, input logic [1:0] exp);
    i_fepc_cpu_model.wr(8'h94, k);
    #1 chk({14'h0, erase_req.valid ? erase_req.kind : 2'h0}, {14'h0, exp});
  endtask : key

  task automatic store(input logic [15:0] a, input logic [7:0] d,
                       input logic fl);
    i_fepc_cpu_model.st(a, d);
    #1 chk({14'h0, flash_wr, xdata_wr}, fl ? 16'h0002 : 16'h0001);
    chk(fl ? flash_addr : xdata_addr, a);
    chk({8'h00, fl ? flash_data : xdata_data}, {8'h00, d});
  endtask : store

  task automatic end_of_test;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // --------------------------------
  // clock, watchdog and sequence
  // --------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end

  initial
  begin
    rstn = 1'b0;
    int_global_en = 1'b0;
    debug_port_en = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    i_fepc_cpu_model.rd(8'hb2, rd);
    chk({8'h00, rd}, 16'h0000);
    key(8'h00, 2'h0);
    i_fepc_cpu_model.wr(8'hb7, 8'h0a);
    key(8'h55, 2'h1);
    chk({9'h0, erase_req.page}, 16'h0005);
    key(8'h55, 2'h0);
    i_fepc_cpu_model.wr(8'hb7, 8'hff);
    foreach (bad_keys[i])
      key(bad_keys[i], 2'h0);
    key(8'h55, 2'h1);
    chk({9'h0, erase_req.page}, 16'h007f);
    i_fepc_cpu_model.wr(8'hb2, 8'h02);
    key(8'haa, 2'h0);
    @(posedge clk) debug_port_en <= 1'b1;
    i_fepc_cpu_model.wr(8'hb2, 8'h02);
    key(8'haa, 2'h2);
    key(8'haa, 2'h0);
    i_fepc_cpu_model.wr(8'hb2, 8'h02);
    i_fepc_cpu_model.wr(8'hb2, 8'h00);
    key(8'haa, 2'h0);
    store(16'h1234, 8'h5a, 1'b0);
    i_fepc_cpu_model.wr(8'hb2, 8'h01);
    i_fepc_cpu_model.rd(8'hb2, rd);
    chk({8'h00, rd}, 16'h0001);
    store(16'habcd, 8'hc3, 1'b1);
    i_fepc_cpu_model.rd(8'hb2, rd);
    chk({8'h00, rd}, 16'h0000);
    store(16'h0f0f, 8'h96, 1'b0);
    @(posedge clk) int_global_en <= 1'b1;
    i_fepc_cpu_model.wr(8'hb2, 8'h01);
    i_fepc_cpu_model.rd(8'hb2, rd);
    chk({8'h00, rd}, 16'h0000);
    store(16'hffff, 8'h01, 1'b0);
    i_fepc_cpu_model.rd(8'h94, rd);
    chk({8'h00, rd}, 16'h0000);
    end_of_test();
  end
endmodule : flash_erase_program_control_bench
`default_nettype wire
